// ==== design/blc_pkg.sv ====
// shared constants, types and field decoders for the backlight config registers
package blc_pkg;

  // register byte offsets on the serial bus
  localparam logic [7:0] BLC_OFS_BRIGHTNESS = 8'h00;
  localparam logic [7:0] BLC_OFS_CURRENT = 8'h02;
  localparam logic [7:0] BLC_OFS_DIMMING = 8'h04;
  localparam logic [7:0] BLC_OFS_FAULT = 8'h06;

  // register reset values
  localparam logic [15:0] BLC_RST_BRIGHTNESS = 16'h0000;
  localparam logic [15:0] BLC_RST_CURRENT = 16'h0fff;
  localparam logic [15:0] BLC_RST_DIMMING = 16'h08a3;
  localparam logic [15:0] BLC_RST_FAULT = 16'h0100;

  // default 7-bit serial device address, value is arbitrary
  localparam logic [6:0] BLC_DEV_ADDR_DEF = 7'h2c;

  // field positions
  localparam int BLC_CUR_LSB = 0;
  localparam int BLC_DIM_PSEUDO = 14;
  localparam int BLC_DIM_RATE_LSB = 12;
  localparam int BLC_DIM_SPAN_LSB = 10;
  localparam int BLC_DIM_SRC_LSB = 8;
  localparam int BLC_DIM_RAMP_LSB = 5;
  localparam int BLC_DIM_DITHER_LSB = 2;
  localparam int BLC_DIM_SCURVE = 1;
  localparam int BLC_FLT_GND = 8;
  localparam int BLC_FLT_SHORT_LSB = 0;

  // brightness source codes
  localparam logic [1:0] BLC_SRC_PWM_PIN = 2'h0;
  localparam logic [1:0] BLC_SRC_REGISTER = 2'h2;

  // linear ramp durations in ms, code 0 means no ramp
  localparam logic [10:0] BLC_RAMP_MS_1 = 11'h001;
  localparam logic [10:0] BLC_RAMP_MS_2 = 11'h002;
  localparam logic [10:0] BLC_RAMP_MS_3 = 11'h032;
  localparam logic [10:0] BLC_RAMP_MS_4 = 11'h064;
  localparam logic [10:0] BLC_RAMP_MS_5 = 11'h0c8;
  localparam logic [10:0] BLC_RAMP_MS_6 = 11'h12c;
  localparam logic [10:0] BLC_RAMP_MS_7 = 11'h1f4;
  // s-curve stretch factor on the linear duration, plain default
  localparam logic [1:0] BLC_SCURVE_STRETCH = 2'h2;

  // spread-spectrum modulation rates in Hz
  localparam logic [10:0] BLC_SSC_HZ_0 = 11'h0c8;
  localparam logic [10:0] BLC_SSC_HZ_1 = 11'h1f4;
  localparam logic [10:0] BLC_SSC_HZ_2 = 11'h320;
  localparam logic [10:0] BLC_SSC_HZ_3 = 11'h4b0;
  // spread-spectrum span in tenths of a percent
  localparam logic [6:0] BLC_SSC_SPAN_0 = 7'h21;
  localparam logic [6:0] BLC_SSC_SPAN_1 = 7'h2b;
  localparam logic [6:0] BLC_SSC_SPAN_2 = 7'h35;
  localparam logic [6:0] BLC_SSC_SPAN_3 = 7'h48;

  // serial slave states
  typedef enum logic [2:0] {
    BLC_IDLE, BLC_ADDR, BLC_ACK_ADDR, BLC_WRITE, BLC_ACK_WRITE, BLC_READ, BLC_READ_ACK
  } blc_i2c_state_t;

  // the four stored registers
  typedef struct packed {
    logic [15:0] brightness_value_reg;
    logic [15:0] sink_current_level_level;
    logic [15:0] dimming_spread_config;
    logic [15:0] fault_detect_config;
  } blc_regs_t;

  // decoded controls toward the analog, boost and sloper logic
  typedef struct packed {
    logic [11:0] sink_current_level;
    logic ssc_pseudo_on;
    logic [1:0] ssc_modulation_rate;
    logic [10:0] ssc_mod_hz;
    logic [6:0] ssc_span_tenths;
    logic [1:0] brightness_source_select;
    logic brightness_from_reg;
    logic [2:0] ramp_code;
    logic [11:0] ramp_ms;
    logic s_curve_ramp_on;
    logic [2:0] dither_bits;
    logic string_ground_short_check_on;
    logic [5:0] short_fault_off;
  } blc_ctrl_t;

  function automatic logic [10:0] blc_ramp_base(input logic [2:0] code);
    case (code)
      3'h1: return BLC_RAMP_MS_1;
      3'h2: return BLC_RAMP_MS_2;
      3'h3: return BLC_RAMP_MS_3;
      3'h4: return BLC_RAMP_MS_4;
      3'h5: return BLC_RAMP_MS_5;
      3'h6: return BLC_RAMP_MS_6;
      3'h7: return BLC_RAMP_MS_7;
      default: return 11'h000;
    endcase
  endfunction

  function automatic logic [10:0] blc_ssc_hz(input logic [1:0] code);
    case (code)
      2'h0: return BLC_SSC_HZ_0;
      2'h1: return BLC_SSC_HZ_1;
      2'h2: return BLC_SSC_HZ_2;
      default: return BLC_SSC_HZ_3;
    endcase
  endfunction

  function automatic logic [6:0] blc_ssc_span(input logic [1:0] code);
    case (code)
      2'h0: return BLC_SSC_SPAN_0;
      2'h1: return BLC_SSC_SPAN_1;
      2'h2: return BLC_SSC_SPAN_2;
      default: return BLC_SSC_SPAN_3;
    endcase
  endfunction

endpackage

// ==== design/blc_sync.sv ====
// two-flop synchroniser for the serial bus pins
`timescale 1ns/1ps
module blc_sync
  import blc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // asynchronous pins in, synchronised levels out
  input wire logic [1:0] pin_async,
  output logic [1:0] pin_sync
);

  typedef struct packed {
    logic [1:0] stage1;
    logic [1:0] stage2;
  } blc_sync_state_t;

  blc_sync_state_t cur, next_cur;

  // stage1 feeds stage2 only
  always_comb begin
    next_cur = cur;
    next_cur.stage1 = pin_async;
    next_cur.stage2 = cur.stage1;
  end

  // idle bus level is high, so reset to ones
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '{stage1: 2'h3, stage2: 2'h3};
    end else begin
      cur <= next_cur;
    end
  end

  assign pin_sync = cur.stage2;

endmodule

// ==== design/blc_regs.sv ====
// serial-bus configuration register bank of the backlight driver
`timescale 1ns/1ps
module blc_regs
  import blc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = BLC_DEV_ADDR_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial bus pins, open drain
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // device state gate
  input wire logic cfg_write_allowed,
  // decoded controls
  output blc_ctrl_t ctrl,
  output logic [15:0] brightness_value_reg
);

  typedef struct packed {
    blc_i2c_state_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic ptr_set;
    logic rw;
    logic rd_more;
    logic sda_oe;
    logic scl_d;
    logic sda_d;
    blc_regs_t regs;
    blc_ctrl_t ctrl;
  } blc_regs_state_t;

  // field decode of the stored registers into controls
  function automatic blc_ctrl_t decode(input blc_regs_t r);
    blc_ctrl_t c;
    logic [10:0] base;
    c.sink_current_level = r.sink_current_level_level[BLC_CUR_LSB +: 12];
    c.ssc_pseudo_on = r.dimming_spread_config[BLC_DIM_PSEUDO];
    c.ssc_modulation_rate = r.dimming_spread_config[BLC_DIM_RATE_LSB +: 2];
    c.ssc_mod_hz = blc_ssc_hz(c.ssc_modulation_rate);
    c.ssc_span_tenths = blc_ssc_span(r.dimming_spread_config[BLC_DIM_SPAN_LSB +: 2]);
    c.brightness_source_select = r.dimming_spread_config[BLC_DIM_SRC_LSB +: 2];
    // reserved source codes fall back to the pin so the lamp never freezes
    c.brightness_from_reg = (c.brightness_source_select == BLC_SRC_REGISTER);
    c.ramp_code = r.dimming_spread_config[BLC_DIM_RAMP_LSB +: 3];
    c.s_curve_ramp_on = r.dimming_spread_config[BLC_DIM_SCURVE];
    base = blc_ramp_base(c.ramp_code);
    // s-curve stretches the linear figure
    c.ramp_ms = c.s_curve_ramp_on ? 12'({1'b0, base} * {10'h000, BLC_SCURVE_STRETCH})
                                  : {1'b0, base};
    // codes above four clamp to the deepest supported dither
    c.dither_bits = (r.dimming_spread_config[BLC_DIM_DITHER_LSB +: 3] > 3'h4) ? 3'h4
                    : r.dimming_spread_config[BLC_DIM_DITHER_LSB +: 3];
    c.string_ground_short_check_on = r.fault_detect_config[BLC_FLT_GND];
    c.short_fault_off = r.fault_detect_config[BLC_FLT_SHORT_LSB +: 6];
    return c;
  endfunction

  // byte read, low byte at the even address, unmapped reads zero
  function automatic logic [7:0] rd_byte(input blc_regs_t r, input logic [7:0] a);
    logic [15:0] w;
    logic [7:0] even;
    w = 16'h0000;
    even = {a[7:1], 1'b0};
    if (even == BLC_OFS_BRIGHTNESS) begin
      w = r.brightness_value_reg;
    end else if (even == BLC_OFS_CURRENT) begin
      w = r.sink_current_level_level;
    end else if (even == BLC_OFS_DIMMING) begin
      w = r.dimming_spread_config;
    end else if (even == BLC_OFS_FAULT) begin
      w = r.fault_detect_config;
    end
    return a[0] ? w[15:8] : w[7:0];
  endfunction

  // replace one byte lane of a word
  function automatic logic [15:0] put(input logic [15:0] w, input logic hi, input logic [7:0] d);
    return hi ? {d, w[7:0]} : {w[15:8], d};
  endfunction

  // byte write, every bit stored as written, unmapped writes dropped
  function automatic blc_regs_t wr_byte(input blc_regs_t r, input logic [7:0] a,
                                        input logic [7:0] d);
    blc_regs_t n;
    logic [7:0] even;
    n = r;
    even = {a[7:1], 1'b0};
    if (even == BLC_OFS_BRIGHTNESS) begin
      n.brightness_value_reg = put(r.brightness_value_reg, a[0], d);
    end else if (even == BLC_OFS_CURRENT) begin
      n.sink_current_level_level = put(r.sink_current_level_level, a[0], d);
    end else if (even == BLC_OFS_DIMMING) begin
      n.dimming_spread_config = put(r.dimming_spread_config, a[0], d);
    end else if (even == BLC_OFS_FAULT) begin
      n.fault_detect_config = put(r.fault_detect_config, a[0], d);
    end
    return n;
  endfunction

  localparam blc_regs_t REGS_RST = '{
    brightness_value_reg: BLC_RST_BRIGHTNESS,
    sink_current_level_level: BLC_RST_CURRENT,
    dimming_spread_config: BLC_RST_DIMMING,
    fault_detect_config: BLC_RST_FAULT
  };
  // controls at reset as a constant, so the reset branch loads no logic
  localparam blc_ctrl_t CTRL_RST = decode(REGS_RST);

  blc_regs_state_t cur, next_cur;
  logic [1:0] pins;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] shifted;
  logic [7:0] rdata;

  blc_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_async({scl_i, sda_i}),
    .pin_sync(pins)
  );

  // bus events from synchronised levels
  assign scl = pins[1];
  assign sda = pins[0];
  assign scl_rise = scl & ~cur.scl_d;
  assign scl_fall = ~scl & cur.scl_d;
  assign start_cond = scl & cur.scl_d & cur.sda_d & ~sda;
  assign stop_cond = scl & cur.scl_d & ~cur.sda_d & sda;
  assign shifted = {cur.shreg[6:0], sda};
  assign rdata = rd_byte(cur.regs, cur.ptr);

  // serial slave and register update
  always_comb begin
    next_cur = cur;
    next_cur.scl_d = scl;
    next_cur.sda_d = sda;
    next_cur.ctrl = decode(cur.regs);
    if (start_cond) begin
      // repeated start keeps the pointer for a following read
      next_cur.st = BLC_ADDR;
      next_cur.bitcnt = 4'h0;
      next_cur.sda_oe = 1'b0;
      next_cur.ptr_set = 1'b0;
    end else if (stop_cond) begin
      next_cur.st = BLC_IDLE;
      next_cur.sda_oe = 1'b0;
    end else begin
      unique case (cur.st)
        BLC_IDLE: begin
          next_cur.sda_oe = 1'b0;
        end
        BLC_ADDR, BLC_WRITE: begin
          if (scl_rise) begin
            next_cur.shreg = shifted;
            next_cur.bitcnt = cur.bitcnt + 4'h1;
          end else if (scl_fall && cur.bitcnt == 4'h8) begin
            if (cur.st == BLC_ADDR) begin
              if (cur.shreg[7:1] == DEV_ADDR) begin
                next_cur.sda_oe = 1'b1;
                next_cur.rw = cur.shreg[0];
                next_cur.st = BLC_ACK_ADDR;
              end else begin
                next_cur.st = BLC_IDLE;
              end
            end else begin
              next_cur.sda_oe = 1'b1;
              next_cur.st = BLC_ACK_WRITE;
              if (!cur.ptr_set) begin
                next_cur.ptr = cur.shreg;
                next_cur.ptr_set = 1'b1;
              end else begin
                // outside standby..normal the byte is acked but not stored
                if (cfg_write_allowed) begin
                  next_cur.regs = wr_byte(cur.regs, cur.ptr, cur.shreg);
                end
                next_cur.ptr = cur.ptr + 8'h01;
              end
            end
          end
        end
        BLC_ACK_ADDR: begin
          if (scl_fall) begin
            next_cur.bitcnt = 4'h0;
            if (cur.rw) begin
              next_cur.shreg = rdata;
              next_cur.sda_oe = ~rdata[7];
              next_cur.st = BLC_READ;
            end else begin
              next_cur.sda_oe = 1'b0;
              next_cur.st = BLC_WRITE;
            end
          end
        end
        BLC_ACK_WRITE: begin
          if (scl_fall) begin
            next_cur.sda_oe = 1'b0;
            next_cur.bitcnt = 4'h0;
            next_cur.st = BLC_WRITE;
          end
        end
        BLC_READ: begin
          if (scl_rise) begin
            next_cur.bitcnt = cur.bitcnt + 4'h1;
          end else if (scl_fall) begin
            if (cur.bitcnt == 4'h8) begin
              next_cur.sda_oe = 1'b0;
              next_cur.ptr = cur.ptr + 8'h01;
              next_cur.st = BLC_READ_ACK;
            end else begin
              next_cur.shreg = {cur.shreg[6:0], 1'b0};
              next_cur.sda_oe = ~cur.shreg[6];
            end
          end
        end
        BLC_READ_ACK: begin
          if (scl_rise) begin
            next_cur.rd_more = ~sda;
          end else if (scl_fall) begin
            if (cur.rd_more) begin
              next_cur.shreg = rdata;
              next_cur.sda_oe = ~rdata[7];
              next_cur.bitcnt = 4'h0;
              next_cur.st = BLC_READ;
            end else begin
              next_cur.st = BLC_IDLE;
            end
          end
        end
      endcase
    end
  end

  // defaults let the device run from its pins with no serial traffic
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cur <= '{st: BLC_IDLE, bitcnt: 4'h0, shreg: 8'h00, ptr: 8'h00, ptr_set: 1'b0,
               rw: 1'b0, rd_more: 1'b0, sda_oe: 1'b0, scl_d: 1'b1, sda_d: 1'b1,
               regs: REGS_RST, ctrl: CTRL_RST};
    end else begin
      cur <= next_cur;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe = cur.sda_oe;
  assign ctrl = cur.ctrl;
  assign brightness_value_reg = cur.regs.brightness_value_reg;

endmodule

// ==== testbench/blc_regs_asserts.sv ====
// concurrent checks on the ports of the backlight config register bank
`timescale 1ns/1ps
module blc_regs_asserts
  import blc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = BLC_DEV_ADDR_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // state gate and decoded controls
  input wire logic cfg_write_allowed,
  input wire blc_ctrl_t ctrl,
  input wire logic [15:0] brightness_value_reg
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // expected ramp length, doubled when the s-curve shape stretches it
  function automatic logic [11:0] ramp_exp(input logic [2:0] c, input logic s);
    logic [11:0] b;
    case (c)
      3'h1: b = 12'h001;
      3'h2: b = 12'h002;
      3'h3: b = 12'h032;
      3'h4: b = 12'h064;
      3'h5: b = 12'h0c8;
      3'h6: b = 12'h12c;
      3'h7: b = 12'h1f4;
      default: b = 12'h000;
    endcase
    return s ? {b[10:0], 1'b0} : b;
  endfunction

  // three cycles with the gate closed, long enough for the ctrl lag
  sequence s_locked;
    !cfg_write_allowed [*3];
  endsequence
  sequence s_just_released;
    $past(sys_rst);
  endsequence

  a_reset_ctrl: assert property (s_just_released |-> ctrl.sink_current_level == 12'hfff
    && !ctrl.ssc_pseudo_on && ctrl.ssc_modulation_rate == 2'h0 && ctrl.ssc_span_tenths == 7'h35
    && ctrl.brightness_source_select == 2'h0 && ctrl.ramp_code == 3'h5 && ctrl.s_curve_ramp_on
    && ctrl.dither_bits == 3'h0 && ctrl.string_ground_short_check_on
    && ctrl.short_fault_off == 6'h00 && brightness_value_reg == 16'h0000 && !sda_oe)
    else $error("control outputs differ from reset values");
  a_rate_hz_map: assert property (ctrl.ssc_mod_hz == (ctrl.ssc_modulation_rate == 2'h0 ? 11'h0c8 :
    ctrl.ssc_modulation_rate == 2'h1 ? 11'h1f4 : ctrl.ssc_modulation_rate == 2'h2 ? 11'h320 : 11'h4b0))
    else $error("modulation rate decode wrong");
  a_span_map: assert property (ctrl.ssc_span_tenths == (ctrl.ssc_span_tenths == 7'h21 ? 7'h21 :
    ctrl.ssc_span_tenths == 7'h2b ? 7'h2b : ctrl.ssc_span_tenths == 7'h35 ? 7'h35 : 7'h48))
    else $error("spread span value outside its table");
  a_source_flag: assert property (ctrl.brightness_from_reg == (ctrl.brightness_source_select == 2'h2))
    else $error("brightness source flag wrong");
  a_ramp_time: assert property (ctrl.ramp_ms == ramp_exp(ctrl.ramp_code, ctrl.s_curve_ramp_on))
    else $error("ramp duration decode wrong");
  a_dither_depth: assert property (ctrl.dither_bits <= 3'h4)
    else $error("dither depth above four bits");
  a_locked_stable: assert property (s_locked |-> $stable(ctrl) && $stable(brightness_value_reg))
    else $error("registers changed while writes were closed");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i, 2) && !sda_o)
    else $error("data line drive changed while clock high");
endmodule

bind blc_regs blc_regs_asserts #(.DEV_ADDR(DEV_ADDR)) i_blc_regs_asserts (.clk(clk),
  .sys_rst(sys_rst), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
  .cfg_write_allowed(cfg_write_allowed), .ctrl(ctrl), .brightness_value_reg(brightness_value_reg));

// ==== testbench/blc_host.sv ====
// host-side serial bus master model for the config register bank
`timescale 1ns/1ps
module blc_host #(
  parameter logic [6:0] ADDR = 7'h2c
) (
  // clock
  input wire logic clk,
  // wired data line level
  input wire logic sda_in,
  // bus drive, open drain on data
  output logic scl,
  output logic sda_low
);
  localparam int HALF = 8; // clocks per clock phase, the device needs at least 2
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data moves two clocks after the fall so it never races the clock edge
  task automatic bit_x(input logic b, output logic s);
    tick(2);
    sda_low <= !b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF / 2);
    s = sda_in;
    tick(HALF / 2);
    scl <= 1'b0;
  endtask
  // start, also used as repeated start
  task automatic start;
    tick(2);
    sda_low <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
  endtask
  task automatic stop;
    tick(2);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
  endtask
  // eight bits msb first, then the acknowledge slot
  task automatic byte_x(input logic [7:0] b, input logic ack_in, output logic [7:0] s,
      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s[i]);
    end
    bit_x(ack_in, ack);
  endtask
  // pointer then low and high byte; nak is high if any byte went unacknowledged
  task automatic write_reg(input logic [7:0] ptr, input logic [15:0] v, output logic nak);
    logic [7:0] d;
    logic a0, a1, a2, a3;
    start();
    byte_x({ADDR, 1'b0}, 1'b1, d, a0);
    byte_x(ptr, 1'b1, d, a1);
    byte_x(v[7:0], 1'b1, d, a2);
    byte_x(v[15:8], 1'b1, d, a3);
    stop();
    nak = a0 | a1 | a2 | a3;
  endtask
  task automatic read_reg(input logic [7:0] ptr, output logic [15:0] v);
    logic [7:0] d;
    logic a;
    start();
    byte_x({ADDR, 1'b0}, 1'b1, d, a);
    byte_x(ptr, 1'b1, d, a);
    start();
    byte_x({ADDR, 1'b1}, 1'b1, d, a);
    byte_x(8'hff, 1'b0, v[7:0], a);
    byte_x(8'hff, 1'b1, v[15:8], a);
    stop();
  endtask
endmodule

// ==== testbench/tb.sv ====
// self-checking bench for the backlight config register bank
`timescale 1ns/1ps
module tb
  import blc_pkg::*;
;
  localparam int LIMIT = 70000; // cycles, the full run needs about 46000
  localparam logic [15:0] RST_V [4] = '{16'h0000, 16'h0fff, 16'h08a3, 16'h0100};
  // documented decode tables: linear ramp ms, modulation Hz, span in tenths of a percent
  localparam logic [15:0] RAMP_MS [8] = '{16'h0000, 16'h0001, 16'h0002, 16'h0032,
    16'h0064, 16'h00c8, 16'h012c, 16'h01f4};
  localparam logic [15:0] SSC_HZ [4] = '{16'h00c8, 16'h01f4, 16'h0320, 16'h04b0};
  localparam logic [15:0] SSC_SPAN [4] = '{16'h0021, 16'h002b, 16'h0035, 16'h0048};
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cfg_write_allowed = 1'b1;
  logic scl, sda_low, sda_o, sda_oe, nak;
  wire sda_bus = !(sda_low | sda_oe); // pull-up unless someone pulls low
  blc_ctrl_t ctrl;
  logic [15:0] brt, v, cur, dim, flt;
  logic [7:0] d;
  logic [31:0] rng = 32'hcdff;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;

  always #20 clk = ~clk;

  blc_regs i_blc_regs (.clk(clk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_bus),
    .sda_o(sda_o), .sda_oe(sda_oe), .cfg_write_allowed(cfg_write_allowed), .ctrl(ctrl),
    .brightness_value_reg(brt));
  blc_host #(.ADDR(BLC_DEV_ADDR_DEF)) i_blc_host (.clk(clk), .sda_in(sda_bus), .scl(scl),
    .sda_low(sda_low));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // reserved bits at reset level, source code 0 or 2, short ramps only linear
  function automatic logic [15:0] san_dim(input logic [15:0] x);
    x = (x & 16'h7efe) | 16'h0001;
    if (x[7:5] == 3'h1 || x[7:5] == 3'h2) x[1] = 1'b0;
    return x;
  endfunction
  function automatic logic [15:0] exp_dith(input logic [2:0] c);
    return (c > 3'h4) ? 16'h0004 : 16'(c);
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [15:0] x);
    i_blc_host.write_reg(ofs, x, nak);
    chk("write ack", 16'(nak), 16'h0000);
  endtask
  task automatic chk_ctrl(input logic [15:0] c, input logic [15:0] m, input logic [15:0] f);
    chk("current", 16'(ctrl.sink_current_level), c & 16'h0fff);
    chk("pseudo", 16'(ctrl.ssc_pseudo_on), 16'(m[14]));
    chk("rate", 16'(ctrl.ssc_modulation_rate), 16'(m[13:12]));
    chk("rate hz", 16'(ctrl.ssc_mod_hz), SSC_HZ[m[13:12]]);
    chk("span", 16'(ctrl.ssc_span_tenths), SSC_SPAN[m[11:10]]);
    chk("from reg", 16'(ctrl.brightness_from_reg), 16'(m[9:8] == 2'h2));
    // s-curve doubles the linear figure
    chk("ramp ms", 16'(ctrl.ramp_ms), m[1] ? RAMP_MS[m[7:5]] << 1 : RAMP_MS[m[7:5]]);
    chk("source", 16'(ctrl.brightness_source_select), 16'(m[9:8]));
    chk("ramp", 16'(ctrl.ramp_code), 16'(m[7:5]));
    chk("dither", 16'(ctrl.dither_bits), exp_dith(m[4:2]));
    chk("s curve", 16'(ctrl.s_curve_ramp_on), 16'(m[1]));
    chk("ground check", 16'(ctrl.string_ground_short_check_on), 16'(f[8]));
    chk("short off", 16'(ctrl.short_fault_off), 16'(f[5:0]));
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    // reset contents of all four registers
    for (int i = 0; i < 4; i++) begin
      i_blc_host.read_reg(8'(2 * i), v);
      chk("reset value", v, RST_V[i]);
    end
    chk_ctrl(16'h0fff, 16'h08a3, 16'h0100);
    $display("test reset values done");
    // two corner sets, then random sets
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      cur = (i == 0) ? 16'hf000 : (i == 1) ? 16'h0000 : rng[15:0] & 16'h0fff;
      dim = (i == 0) ? 16'h7eff : (i == 1) ? 16'h0001 : san_dim(rng[31:16]);
      rng = xs(rng);
      flt = (i == 0) ? 16'h013f : (i == 1) ? 16'h0000 : rng[15:0] & 16'h013f;
      wr(BLC_OFS_CURRENT, cur);
      wr(BLC_OFS_DIMMING, dim);
      wr(BLC_OFS_FAULT, flt);
      wr(BLC_OFS_BRIGHTNESS, rng[31:16]);
      i_blc_host.read_reg(BLC_OFS_CURRENT, v);
      chk("current reg", v, cur);
      i_blc_host.read_reg(BLC_OFS_DIMMING, v);
      chk("dimming reg", v, dim);
      i_blc_host.read_reg(BLC_OFS_FAULT, v);
      chk("fault reg", v, flt);
      i_blc_host.read_reg(BLC_OFS_BRIGHTNESS, v);
      chk("brightness reg", v, rng[31:16]);
      chk("brightness out", brt, rng[31:16]);
      chk_ctrl(cur, dim, flt);
    end
    $display("test write and read back done");
    // writes outside the allowed states are dropped
    cfg_write_allowed <= 1'b0;
    wr(BLC_OFS_CURRENT, ~cur);
    i_blc_host.read_reg(BLC_OFS_CURRENT, v);
    chk("locked current", v, cur);
    chk_ctrl(cur, dim, flt);
    cfg_write_allowed <= 1'b1;
    $display("test locked writes done");
    // unmapped offset reads zero, foreign address gets no acknowledge
    wr(8'h08, 16'h5a5a);
    i_blc_host.read_reg(8'h08, v);
    chk("unmapped", v, 16'h0000);
    i_blc_host.start();
    i_blc_host.byte_x({BLC_DEV_ADDR_DEF ^ 7'h01, 1'b0}, 1'b1, d, nak);
    i_blc_host.stop();
    chk("foreign address", 16'(nak), 16'h0001);
    $display("test address decode done");
    // second reset in mid-run restores defaults
    sys_rst <= 1'b1;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    i_blc_host.read_reg(BLC_OFS_DIMMING, v);
    chk("dimming after reset", v, 16'h08a3);
    chk("brightness after reset", brt, 16'h0000);
    chk_ctrl(16'h0fff, 16'h08a3, 16'h0100);
    $display("test second reset done");
    close_out();
  end
endmodule
